// ===== deac_ctrl.sv
// Register front end of the data EEPROM access controller
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module deac_ctrl #(
    parameter int ADDR_BITS = 8,
    parameter int PWRT_CYC  = deac_pkg::PWRT_CYCLES,
    parameter int WR_CYC    = deac_pkg::WR_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        external_reset_pin,
    input  wire logic        watchdog_timer_reset,
    input  wire logic        brownout_reset,
    input  wire logic        pwrt_enable,
    input  wire logic        code_protect,
    input  wire logic [7:0]  prog_addr,
    output logic [7:0]       prog_rdata,
    output logic             prog_denied
);
    localparam logic [deac_pkg::CNT_W-1:0] PWRT_LIM =
        deac_pkg::CNT_W'(PWRT_CYC);
    localparam logic [3:0] GAP_LIM = 4'(deac_pkg::UNLOCK_GAP_CYC);

    deac_nvm_if nvm ();

    logic [4:0]                 sync1_r;
    logic [4:0]                 sync2_r;
    logic                       ack_r;
    logic [31:0]                rdata_r;
    logic [31:0]                rdata_nxt;
    logic [7:0]                 data_r;
    logic [7:0]                 addr_r;
    logic                       rd_r;
    logic                       wr_r;
    logic                       write_allow_bit_r;
    logic                       write_abort_flag_r;
    logic                       done_flag_r;
    deac_pkg::deac_unlock_t     ul_state_r;
    logic [3:0]                 ul_gap_r;
    logic [deac_pkg::CNT_W-1:0] pwrt_cnt_r;
    logic [7:0]                 prog_rdata_r;
    logic                       prog_denied_r;
    logic [7:0]                 idx;
    logic [7:0]                 wdat;
    logic                       hit;
    logic                       bus_wr;
    logic                       warm;
    logic                       pwrt_busy;
    logic                       wr_ctrl;
    logic                       wr_unlock;
    logic                       wr_go;
    logic                       rd_go;

    // Reset sources and straps are asynchronous to mclk
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {code_protect, pwrt_enable, brownout_reset,
                        watchdog_timer_reset, external_reset_pin};
            sync2_r <= sync1_r;
        end
    end

    assign warm = |sync2_r[2:0];
    assign idx  = avs_address[9:2];
    assign hit  = (avs_address[1:0] == 2'h0);
    assign wdat = avs_writedata[7:0];
    // Core is held during a warm reset, so its writes are dropped
    assign bus_wr    = avs_write && ack_r && avs_byteenable[0] && hit && !warm;
    assign wr_ctrl   = bus_wr && (idx == deac_pkg::IDX_CTRL);
    assign wr_unlock = bus_wr && (idx == deac_pkg::IDX_UNLOCK);
    assign pwrt_busy = sync2_r[3] && (pwrt_cnt_r != PWRT_LIM);

    assign wr_go = wr_ctrl && wdat[deac_pkg::CTRL_WR] && write_allow_bit_r
        && ul_state_r == deac_pkg::DEAC_UL_KEY2
        && !pwrt_busy && !wr_r;
    assign rd_go = wr_ctrl && wdat[deac_pkg::CTRL_RD] && !wr_r;

    // One wait state per access keeps read data registered
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata    = rdata_r;

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit) begin
            unique case (idx)
                deac_pkg::IDX_DATA:  rdata_nxt[7:0] = data_r;
                deac_pkg::IDX_ADDR:  rdata_nxt[7:0] = addr_r;
                deac_pkg::IDX_CTRL:  rdata_nxt[3:0] =
                    {write_abort_flag_r, write_allow_bit_r, wr_r, rd_r};
                deac_pkg::IDX_FLAGS: rdata_nxt[deac_pkg::FLAG_WR_DONE] =
                    done_flag_r;
                default:             rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
            if (avs_read && !ack_r) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Data and address survive warm resets for a retry
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_r <= deac_pkg::DATA_RST;
            addr_r <= deac_pkg::ADDR_RST;
        end else begin
            if (rd_r) begin
                data_r <= nvm.rdata;
            end else if (bus_wr && idx == deac_pkg::IDX_DATA) begin
                data_r <= wdat;
            end
            if (bus_wr && idx == deac_pkg::IDX_ADDR) begin
                addr_r <= wdat;
            end
        end
    end

    // Start bits: zero writes do nothing; hardware ends them
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            rd_r <= rd_go;
            if (warm || nvm.done) begin
                wr_r <= 1'b0;
            end else if (wr_go) begin
                wr_r <= 1'b1;
            end
        end
    end

    // Only power-on reset or software touch write-allow
    always_ff @(posedge mclk) begin
        if (rst) begin
            write_allow_bit_r <= 1'b0;
        end else if (wr_ctrl) begin
            write_allow_bit_r <= wdat[deac_pkg::CTRL_WRITE_ALLOW_BIT];
        end
    end

    // Abort set wins over a software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            write_abort_flag_r <= 1'b0;
        end else if (warm && wr_r) begin
            write_abort_flag_r <= 1'b1;
        end else if (nvm.done) begin
            write_abort_flag_r <= 1'b0;
        end else if (wr_ctrl) begin
            write_abort_flag_r <= wdat[deac_pkg::CTRL_WRITE_ABORT_FLAG];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            done_flag_r <= 1'b0;
        end else if (nvm.done) begin
            done_flag_r <= 1'b1;
        end else if (bus_wr && idx == deac_pkg::IDX_FLAGS) begin
            done_flag_r <= wdat[deac_pkg::FLAG_WR_DONE];
        end
    end

    // Unlock keys must be consecutive writes within a short gap
    always_ff @(posedge mclk) begin
        if (rst || warm) begin
            ul_state_r <= deac_pkg::DEAC_UL_IDLE;
            ul_gap_r   <= 4'h0;
        end else if (bus_wr) begin
            ul_gap_r <= 4'h0;
            if (wr_unlock && wdat == deac_pkg::UNLOCK_KEY1) begin
                ul_state_r <= deac_pkg::DEAC_UL_KEY1;
            end else if (wr_unlock && wdat == deac_pkg::UNLOCK_KEY2 &&
                         ul_state_r == deac_pkg::DEAC_UL_KEY1) begin
                ul_state_r <= deac_pkg::DEAC_UL_KEY2;
            end else begin
                ul_state_r <= deac_pkg::DEAC_UL_IDLE;
            end
        end else if (ul_state_r != deac_pkg::DEAC_UL_IDLE) begin
            if (ul_gap_r == GAP_LIM) begin
                ul_state_r <= deac_pkg::DEAC_UL_IDLE;
            end else begin
                ul_gap_r <= ul_gap_r + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pwrt_cnt_r <= '0;
        end else if (pwrt_cnt_r != PWRT_LIM) begin
            pwrt_cnt_r <= pwrt_cnt_r + 1'b1;
        end
    end

    // Programmer port is cut off under code protection
    always_ff @(posedge mclk) begin
        if (rst) begin
            prog_rdata_r  <= 8'h00;
            prog_denied_r <= 1'b0;
        end else begin
            prog_denied_r <= sync2_r[4];
            prog_rdata_r  <= sync2_r[4] ? 8'h00 : nvm.prog_rdata;
        end
    end

    assign prog_rdata    = prog_rdata_r;
    assign prog_denied   = prog_denied_r;
    assign nvm.addr      = addr_r;
    assign nvm.wdata     = data_r;
    assign nvm.prog_addr = prog_addr;
    assign nvm.wr_start  = wr_go;
    assign nvm.abort     = warm;

    deac_array #(
        .ADDR_BITS (ADDR_BITS),
        .WR_CYC    (WR_CYC)
    ) u_array (
        .mclk (mclk),
        .rst  (rst),
        .nvm  (nvm)
    );

    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_rd_one_cycle: assert property (rd_r |=> !rd_r)
        else $error("read start held over one cycle");
    a_rd_data_next: assert property (
        rd_r |=> data_r == $past(nvm.rdata))
        else $error("read byte not loaded next cycle");
    a_wr_needs_allow: assert property (
        $rose(wr_r) |-> $past(write_allow_bit_r))
        else $error("write started without write allow");
    a_wr_needs_unlock: assert property (
        $rose(wr_r) |-> $past(ul_state_r) == deac_pkg::DEAC_UL_KEY2)
        else $error("write started without unlock");
    a_wr_pwrt_block: assert property (
        $rose(wr_r) |-> !$past(pwrt_busy))
        else $error("write started during power-up timer");
    a_write_allow_bit_sw_only: assert property (
        $fell(write_allow_bit_r) |-> $past(wr_ctrl))
        else $error("write allow cleared by hardware");
    a_done_sets_flag: assert property (
        nvm.done |=> done_flag_r && !wr_r && !write_abort_flag_r)
        else $error("completion not reported");
    a_abort_flag_set: assert property (
        warm && wr_r |=> write_abort_flag_r && !wr_r)
        else $error("aborted write not flagged");
    a_abort_keeps_regs: assert property (
        warm && wr_r && !rd_r |=> $stable(data_r) && $stable(addr_r))
        else $error("registers lost on aborting reset");
    a_ctrl_upper_zero: assert property (
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_prog_blocked: assert property (
        prog_denied |-> prog_rdata == 8'h00)
        else $error("programmer read under protection");

    c_read_done: cover property (rd_r ##1 !rd_r);
    c_write_done: cover property (wr_r ##1 nvm.done);
    c_write_abort: cover property (wr_r && warm);
    c_wr_refused: cover property (wr_ctrl && wdat[1] && !write_allow_bit_r);
endmodule
`default_nettype wire

// ===== deac_pkg.sv
// Constants and types for the data EEPROM access controller
package deac_pkg;
    localparam int CLK_MHZ        = 125;
    localparam int PWRT_MS        = 72;
    localparam int PWRT_CYCLES    = PWRT_MS * 1000 * CLK_MHZ;
    localparam int WR_TIME_US     = 4000;
    localparam int WR_CYCLES      = WR_TIME_US * CLK_MHZ;
    localparam int UNLOCK_GAP_CYC = 8;
    localparam int CNT_W          = 24;

    localparam logic [7:0] IDX_FLAGS  = 8'h0C;
    localparam logic [7:0] IDX_DATA   = 8'h9A;
    localparam logic [7:0] IDX_ADDR   = 8'h9B;
    localparam logic [7:0] IDX_CTRL   = 8'h9C;
    localparam logic [7:0] IDX_UNLOCK = 8'h9D;

    localparam int CTRL_RD      = 0;
    localparam int CTRL_WR      = 1;
    localparam int CTRL_WRITE_ALLOW_BIT    = 2;
    localparam int CTRL_WRITE_ABORT_FLAG   = 3;
    localparam int FLAG_WR_DONE = 7;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] DATA_RST    = 8'h00;
    localparam logic [7:0] ADDR_RST    = 8'h00;

    typedef enum logic [2:0] {
        DEAC_UL_IDLE = 3'b001,
        DEAC_UL_KEY1 = 3'b010,
        DEAC_UL_KEY2 = 3'b100
    } deac_unlock_t;

    typedef enum logic [2:0] {
        DEAC_AR_IDLE  = 3'b001,
        DEAC_AR_ERASE = 3'b010,
        DEAC_AR_PROG  = 3'b100
    } deac_array_t;
endpackage

// ===== deac_nvm_if.sv
// Link between the register front end and the byte array
`timescale 1ns/1ns
`default_nettype none
interface deac_nvm_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] prog_addr;
    logic [7:0] prog_rdata;
    logic       wr_start;
    logic       abort;
    logic       busy;
    logic       done;

    modport ctrl (
        output addr, wdata, prog_addr, wr_start, abort,
        input  rdata, prog_rdata, busy, done
    );
    modport mem (
        input  addr, wdata, prog_addr, wr_start, abort,
        output rdata, prog_rdata, busy, done
    );
endinterface
`default_nettype wire

// ===== deac_array.sv
// Byte array with timed erase-then-program write cycle
`timescale 1ns/1ns
`default_nettype none
module deac_array #(
    parameter int ADDR_BITS = 8,
    parameter int WR_CYC    = deac_pkg::WR_CYCLES
) (
    input  wire logic mclk,
    input  wire logic rst,
    deac_nvm_if.mem   nvm
);
    localparam int DEPTH = 2 ** ADDR_BITS;
    localparam logic [deac_pkg::CNT_W-1:0] ERASE_LIM =
        deac_pkg::CNT_W'(WR_CYC / 2);
    localparam logic [deac_pkg::CNT_W-1:0] PROG_LIM =
        deac_pkg::CNT_W'(WR_CYC - WR_CYC / 2);

    logic [7:0]                 mem_r [DEPTH];
    deac_pkg::deac_array_t      state_r;
    logic [deac_pkg::CNT_W-1:0] cnt_r;
    logic [7:0]                 waddr_r;
    logic [7:0]                 wdata_r;
    logic                       done_r;
    logic                       cpu_ok;
    logic                       prog_ok;
    logic                       wr_ok;

    // Small variant decodes the top address bit: no aliasing
    assign cpu_ok  = (ADDR_BITS == 8) || !nvm.addr[7];
    assign prog_ok = (ADDR_BITS == 8) || !nvm.prog_addr[7];
    assign wr_ok   = (ADDR_BITS == 8) || !waddr_r[7];

    assign nvm.rdata = cpu_ok ?
        mem_r[nvm.addr[ADDR_BITS-1:0]] : 8'h00;
    assign nvm.prog_rdata = prog_ok ?
        mem_r[nvm.prog_addr[ADDR_BITS-1:0]] : 8'h00;
    assign nvm.busy = (state_r != deac_pkg::DEAC_AR_IDLE);
    assign nvm.done = done_r;

    // Write time comes from this timer only
    always_ff @(posedge mclk) begin
        done_r <= 1'b0;
        if (rst || nvm.abort) begin
            state_r <= deac_pkg::DEAC_AR_IDLE;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                deac_pkg::DEAC_AR_IDLE: begin
                    if (nvm.wr_start) begin
                        state_r <= deac_pkg::DEAC_AR_ERASE;
                        cnt_r   <= '0;
                    end
                end
                deac_pkg::DEAC_AR_ERASE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == ERASE_LIM - 1'b1) begin
                        state_r <= deac_pkg::DEAC_AR_PROG;
                        cnt_r   <= '0;
                    end
                end
                deac_pkg::DEAC_AR_PROG: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == PROG_LIM - 1'b1) begin
                        state_r <= deac_pkg::DEAC_AR_IDLE;
                        done_r  <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            waddr_r <= 8'h00;
            wdata_r <= 8'h00;
        end else if (nvm.wr_start && state_r == deac_pkg::DEAC_AR_IDLE) begin
            waddr_r <= nvm.addr;
            wdata_r <= nvm.wdata;
        end
    end

    // Contents are nonvolatile, so no reset; erase precedes program
    always_ff @(posedge mclk) begin
        if (!rst && !nvm.abort && wr_ok) begin
            if (state_r == deac_pkg::DEAC_AR_ERASE &&
                cnt_r == ERASE_LIM - 1'b1) begin
                mem_r[waddr_r[ADDR_BITS-1:0]] <= deac_pkg::ERASED_BYTE;
            end else if (state_r == deac_pkg::DEAC_AR_PROG &&
                         cnt_r == PROG_LIM - 1'b1) begin
                mem_r[waddr_r[ADDR_BITS-1:0]] <= wdata_r;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the data EEPROM access controller
`timescale 1ns/1ns
`default_nettype none
module tb;
    // Short counts keep the run brief; expectations derive from these
    localparam int         WR_CYC   = 20;
    localparam int         PWRT_CYC = 50;
    localparam logic [7:0] R_DAT    = deac_pkg::IDX_DATA;
    localparam logic [7:0] R_ADR    = deac_pkg::IDX_ADDR;
    localparam logic [7:0] R_CTL    = deac_pkg::IDX_CTRL;
    localparam logic [7:0] R_UNL    = deac_pkg::IDX_UNLOCK;
    localparam logic [7:0] R_FLG    = deac_pkg::IDX_FLAGS;

    logic        mclk           = 1'h0;
    logic        rst            = 1'h1;
    logic [9:0]  avs_address    = 10'h000;
    logic        avs_read       = 1'h0;
    logic        avs_write      = 1'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_writedata  = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  warm_rst       = 3'h0;
    logic        pwrt_enable    = 1'h1;
    logic        code_protect   = 1'h0;
    logic [7:0]  prog_addr      = 8'h00;
    logic [7:0]  prog_rdata;
    logic        prog_denied;
    logic [31:0] rdata_s;
    logic        wait_s;
    int          err_total      = 0;
    int          num_checks     = 0;
    int          cyc            = 0;
    logic [7:0]  mem [256];
    logic [31:0] rv;
    logic [31:0] rv_s;

    always #4 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    deac_ctrl #(
        .ADDR_BITS (8),
        .PWRT_CYC  (PWRT_CYC),
        .WR_CYC    (WR_CYC)
    ) deac_ctrl_i (
        .mclk                 (mclk),
        .rst                  (rst),
        .avs_address          (avs_address),
        .avs_read             (avs_read),
        .avs_write            (avs_write),
        .avs_byteenable       (avs_byteenable),
        .avs_writedata        (avs_writedata),
        .avs_readdata         (avs_readdata),
        .avs_waitrequest      (avs_waitrequest),
        .external_reset_pin   (warm_rst[0]),
        .watchdog_timer_reset (warm_rst[1]),
        .brownout_reset       (warm_rst[2]),
        .pwrt_enable          (pwrt_enable),
        .code_protect         (code_protect),
        .prog_addr            (prog_addr),
        .prog_rdata           (prog_rdata),
        .prog_denied          (prog_denied)
    );

    // Small variant on the same bus: same timing, only the array differs
    deac_ctrl #(
        .ADDR_BITS (7),
        .PWRT_CYC  (PWRT_CYC),
        .WR_CYC    (WR_CYC)
    ) deac_ctrl_s_i (
        .mclk                 (mclk),
        .rst                  (rst),
        .avs_address          (avs_address),
        .avs_read             (avs_read),
        .avs_write            (avs_write),
        .avs_byteenable       (avs_byteenable),
        .avs_writedata        (avs_writedata),
        .avs_readdata         (rdata_s),
        .avs_waitrequest      (wait_s),
        .external_reset_pin   (warm_rst[0]),
        .watchdog_timer_reset (warm_rst[1]),
        .brownout_reset       (warm_rst[2]),
        .pwrt_enable          (pwrt_enable),
        .code_protect         (code_protect),
        .prog_addr            (prog_addr),
        .prog_rdata           (),
        .prog_denied          ()
    );

    function automatic logic [31:0] ctl(input logic ab, al, w);
        return {28'h0000000, ab, al, w, 1'h0};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tend(input string n);
        $display("test %s finished, mismatches so far %0d", n, err_total);
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] wd, input logic [3:0] be);
        @(posedge mclk);
        avs_address    <= {idx, 2'h0};
        avs_read       <= ~w;
        avs_write      <= w;
        avs_byteenable <= be;
        avs_writedata  <= {24'h000000, wd};
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'h0 || wait_s !== 1'h0);
        rv   = avs_readdata;
        rv_s = rdata_s;
        avs_read  <= 1'h0;
        avs_write <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'h1, idx, d, 4'h1);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
                         input string n);
        bus(1'h0, idx, 8'h00, 4'h1);
        chk(n, rv, exp);
    endtask

    task automatic start_wr(input logic [7:0] a, input logic [7:0] d);
        wr(R_DAT, d);
        wr(R_ADR, a);
        wr(R_CTL, 8'h04);
        wr(R_UNL, deac_pkg::UNLOCK_KEY1);
        wr(R_UNL, deac_pkg::UNLOCK_KEY2);
        wr(R_CTL, 8'h06);
    endtask

    // Polls the start bit; elapsed cycles counted from t0
    task automatic wait_done(input int t0);
        int n;
        n = 0;
        do begin
            bus(1'h0, R_CTL, 8'h00, 4'h1);
            n++;
        end while (rv[1] !== 1'h0 && n < 40);
        n = cyc - t0;
        chk("write time", 32'(n >= WR_CYC - 1 && n <= WR_CYC + 8), 32'h1);
    endtask

    task automatic rd_arr(input logic [7:0] a);
        wr(R_ADR, a);
        wr(R_CTL, 8'h05);
        rdchk(R_DAT, {24'h000000, mem[a]}, "array byte");
        // Small array decodes the top address bit: such places read zero
        chk("small array byte", rv_s,
            a[7] ? 32'h00000000 : {24'h000000, mem[a]});
    endtask

    initial begin
        int t0;
        logic [7:0] a;
        logic [7:0] d;
        void'($urandom(32'h9C46));
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        rdchk(R_DAT, 32'h0, "data at reset");
        rdchk(R_ADR, 32'h0, "address at reset");
        rdchk(R_CTL, 32'h0, "control at reset");
        rdchk(R_UNL, 32'h0, "unlock port");
        rdchk(8'h50, 32'h0, "unmapped read");
        tend("reset values");
        start_wr(8'h10, 8'h3C);
        rdchk(R_CTL, ctl(0, 1, 0), "start under power-up timer");
        repeat (PWRT_CYC) @(posedge mclk);
        wr(R_CTL, 8'h00);
        wr(R_UNL, 8'h55);
        wr(R_UNL, 8'hAA);
        wr(R_CTL, 8'h06);
        rdchk(R_CTL, ctl(0, 1, 0), "start without allow");
        wr(R_UNL, 8'hAA);
        wr(R_UNL, 8'h55);
        wr(R_CTL, 8'h06);
        rdchk(R_CTL, ctl(0, 1, 0), "keys swapped");
        wr(R_UNL, 8'h55);
        wr(R_UNL, 8'hAA);
        repeat (12) @(posedge mclk);
        wr(R_CTL, 8'h06);
        rdchk(R_CTL, ctl(0, 1, 0), "late start");
        rdchk(R_FLG, 32'h0, "no done flag");
        tend("refused starts");
        // Fixed places keep the top address bit clear for the small array
        start_wr(8'h10, 8'hA5);
        t0 = cyc;
        rdchk(R_CTL, ctl(0, 1, 1), "write busy");
        wait_done(t0);
        rdchk(R_FLG, 32'h80, "done flag");
        rdchk(R_CTL, ctl(0, 1, 0), "clean finish");
        wr(R_FLG, 8'h00);
        rdchk(R_FLG, 32'h0, "done flag cleared");
        mem[8'h10] = 8'hA5;
        rd_arr(8'h10);
        rdchk(R_CTL, ctl(0, 1, 0), "read bit self clears");
        rdchk(R_DAT, 32'hA5, "read byte held");
        start_wr(8'h10, 8'h5A);
        wait_done(cyc);
        mem[8'h10] = 8'h5A;
        rd_arr(8'h10);
        tend("basic write");
        start_wr(8'h20, 8'h66);
        t0 = cyc;
        wr(R_CTL, 8'h00);
        rdchk(R_CTL, ctl(0, 0, 1), "start bit kept");
        wr(R_DAT, 8'h99);
        wr(R_CTL, 8'h01);
        wait_done(t0);
        rdchk(R_DAT, 32'h99, "read during write");
        mem[8'h20] = 8'h66;
        rd_arr(8'h20);
        tend("requests during write");
        for (int k = 0; k < 3; k++) begin
            start_wr(8'h30 + 8'(k), 8'hC0 + 8'(k));
            repeat (3) @(posedge mclk);
            warm_rst[k] <= 1'h1;
            repeat (6) @(posedge mclk);
            warm_rst[k] <= 1'h0;
            repeat (6) @(posedge mclk);
            rdchk(R_CTL, ctl(1, 1, 0), "aborted write");
            rdchk(R_DAT, 32'hC0 + k, "data kept");
            rdchk(R_ADR, 32'h30 + k, "address kept");
            wr(R_UNL, 8'h55);
            wr(R_UNL, 8'hAA);
            wr(R_CTL, 8'h0E);
            wait_done(cyc);
            rdchk(R_CTL, ctl(0, 1, 0), "retry clears abort");
            mem[8'h30 + 8'(k)] = 8'hC0 + 8'(k);
            rd_arr(8'h30 + 8'(k));
        end
        tend("warm reset abort");
        bus(1'h1, R_DAT, 8'h11, 4'h0);
        rdchk(R_DAT, {24'h000000, mem[8'h32]}, "lane disabled");
        wr(R_CTL, 8'hF4);
        rdchk(R_CTL, ctl(0, 1, 0), "upper control bits");
        prog_addr <= 8'h10;
        repeat (4) @(posedge mclk);
        chk("programmer byte", {24'h000000, prog_rdata}, 32'h5A);
        chk("programmer denied", {31'h0, prog_denied}, 32'h0);
        code_protect <= 1'h1;
        repeat (6) @(posedge mclk);
        chk("protected byte", {24'h000000, prog_rdata}, 32'h0);
        chk("protected denied", {31'h0, prog_denied}, 32'h1);
        rd_arr(8'h10);
        code_protect <= 1'h0;
        tend("code protection");
        // Top-half corners first, then random places and bytes
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 8'hFF : (i == 1) ? 8'h80 : 8'($urandom);
            d = 8'($urandom);
            start_wr(a, d);
            wait_done(cyc);
            mem[a] = d;
            rd_arr(a);
        end
        tend("random writes");
        test_done();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
